// *** core/isa_bus_signal_control.sv ***
// ISA side signal control: ownership, memory commands, AEN, BALE, errors
`timescale 1ns/10ps
`default_nettype none
module isa_bus_signal_control
   import isa_sig_pkg::*;
#(
   parameter int BALE_CYCLES = BALE_CYC,
   parameter int CMD_CYCLES = CMD_CYC
) (
   // Clock and PCI reset
   input wire logic clock,
   input wire logic resetn,
   // Cycle requests from the bridge core
   input wire logic req_valid,
   input wire cyc_req_t req,
   output logic req_ready,
   output logic done,
   output logic [SD_W-1:0] rdata,
   // Ownership: external ISA master holds the bus
   input wire logic master_own,
   // Channel check status toward the host
   input wire logic err_clear,
   output logic chk_error,
   // Upper latchable address
   input wire logic [LA_W-1:0] la_in,
   output logic [LA_W-1:0] la_out,
   output logic la_oe,
   // System data
   input wire logic [SD_W-1:0] sd_in,
   output logic [SD_W-1:0] sd_out,
   output logic sd_oe,
   // Byte high enable, active low
   input wire logic sbhe_n_in,
   output logic sbhe_n_out,
   output logic sbhe_n_oe,
   // Memory read and write commands, active low
   input wire logic memr_n_in,
   output logic memr_n_out,
   output logic memr_n_oe,
   input wire logic memw_n_in,
   output logic memw_n_out,
   output logic memw_n_oe,
   // Standard memory commands, active low
   output logic smemr_n,
   output logic smemw_n,
   output logic smem_oe,
   // Address enable, latch enable and reset drive
   output logic aen,
   output logic bale,
   output logic rstdrv,
   // Channel check, active low
   input wire logic iochk_n
);
   // Phase counter is eight bits wide, so longer phases cannot be served
   if (BALE_CYCLES < 1 || BALE_CYCLES > 255 || CMD_CYCLES < 1 || CMD_CYCLES > 255) begin : g_bad
      $error("Phase lengths must lie between 1 and 255 cycles");
   end

   // Address lies below the 1 Mbyte boundary
   function automatic logic below_meg(input logic [LA_W-1:0] la);
      below_meg = (la[LA_W-1:MEG_BIT-LA_LSB] == '0);
   endfunction

   // Cycle uses the DMA path
   function automatic logic is_dma(input cyc_kind_t k);
      is_dma = (k == K_DMA_RD) || (k == K_DMA_WR);
   endfunction

   typedef enum logic [1:0] {
      S_IDLE,
      S_ADDR,
      S_CMD
   } state_t;

   localparam logic [CNT_W-1:0] BALE_LAST = CNT_W'(BALE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_CYCLES - 1);

   state_t state_q, state_d;                  // Cycle sequencer
   logic [CNT_W-1:0] cnt_q, cnt_d;            // Phase counter
   cyc_req_t cur_q, cur_d;                    // Cycle being run
   logic own_q, own_d;                        // Bridge owns the bus
   pin_drv_t memr_q, memr_d;                  // Memory read pin
   pin_drv_t memw_q, memw_d;                  // Memory write pin
   pin_drv_t sbhe_q, sbhe_d;                  // Byte high enable pin
   logic [LA_W-1:0] la_q, la_d;               // Address drive value
   logic la_oe_q, la_oe_d;                    // Address drive enable
   logic [SD_W-1:0] sd_q, sd_d;               // Data drive value
   logic sd_oe_q, sd_oe_d;                    // Data drive enable
   logic aen_q, aen_d;                        // Address enable
   logic bale_q, bale_d;                      // Latch enable
   logic ready_q, ready_d;                    // Request may be taken
   logic done_q, done_d;                      // Cycle end pulse
   logic [SD_W-1:0] rdata_q, rdata_d;         // Captured read data
   logic rstdrv_q;                            // Reset drive
   logic chk_q, chk_d;                        // Sticky channel check
   logic bus_memr_n, bus_memw_n, low_meg;     // Feeds the standard commands
   logic is_rd, is_wr;                        // Current cycle direction

   assign is_rd = (cur_q.kind == K_MEM_RD) || (cur_q.kind == K_DMA_RD) ||
                  (cur_q.kind == K_REFRESH);
   assign is_wr = (cur_q.kind == K_MEM_WR) || (cur_q.kind == K_DMA_WR);

   // Sequencer and pin drive: address phase with BALE, then command phase
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cur_d = cur_q;
      own_d = own_q;
      memr_d = memr_q;
      memw_d = memw_q;
      sbhe_d = sbhe_q;
      la_d = la_q;
      la_oe_d = la_oe_q;
      sd_d = sd_q;
      sd_oe_d = sd_oe_q;
      aen_d = aen_q;
      bale_d = bale_q;
      ready_d = 1'b0;
      done_d = 1'b0;
      rdata_d = rdata_q;
      unique case (state_q)
         S_IDLE: begin
            // Address, command and byte-enable directions move only when ownership changes hands
            if (own_q == master_own) begin
               own_d = ~master_own;
               la_oe_d = ~master_own;
               memr_d.oe = ~master_own;
               memw_d.oe = ~master_own;
               sbhe_d.oe = ~master_own;
            end
            // External master cycles keep BALE high
            bale_d = master_own;
            aen_d = 1'b0;
            ready_d = ~master_own && own_q;
            if (req_valid && ready_q && !master_own) begin
               cur_d = req;
               la_d = req.addr[ADDR_W-1:LA_LSB];
               // Upper lane flag; refresh never uses it
               sbhe_d.o = ~(req.bhe && req.kind != K_REFRESH);
               // DMA and refresh hide the cycle from I/O slaves
               aen_d = is_dma(req.kind) || req.kind == K_REFRESH;
               bale_d = 1'b1;
               cnt_d = '0;
               ready_d = 1'b0;
               state_d = S_ADDR;
            end
         end
         S_ADDR: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == BALE_LAST) begin
               // Falling BALE latches LA; DMA keeps it high
               bale_d = is_dma(cur_q.kind);
               memr_d.o = ~is_rd;
               memw_d.o = ~is_wr;
               sd_d = cur_q.wdata;
               sd_oe_d = is_wr;
               cnt_d = '0;
               state_d = S_CMD;
            end
         end
         S_CMD: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CMD_LAST) begin
               memr_d.o = CMD_IDLE_N;
               memw_d.o = CMD_IDLE_N;
               sd_oe_d = 1'b0;
               aen_d = 1'b0;
               bale_d = 1'b0;
               // Refresh data is meaningless and is not kept
               if (is_rd && cur_q.kind != K_REFRESH)
                  rdata_d = sd_in;
               done_d = 1'b1;
               state_d = S_IDLE;
            end
         end
      endcase
   end

   // Sequencer registers; bus pins float and AEN is low in reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_IDLE;
         cnt_q <= '0;
         cur_q <= '0;
         own_q <= 1'b0;
         memr_q <= '{o: CMD_IDLE_N, oe: 1'b0};
         memw_q <= '{o: CMD_IDLE_N, oe: 1'b0};
         sbhe_q <= '{o: CMD_IDLE_N, oe: 1'b0};
         la_q <= LA_RST;
         la_oe_q <= 1'b0;
         sd_q <= SD_RST;
         sd_oe_q <= 1'b0;
         aen_q <= AEN_RST;
         bale_q <= BALE_RST;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= SD_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cur_q <= cur_d;
         own_q <= own_d;
         memr_q <= memr_d;
         memw_q <= memw_d;
         sbhe_q <= sbhe_d;
         la_q <= la_d;
         la_oe_q <= la_oe_d;
         sd_q <= sd_d;
         sd_oe_q <= sd_oe_d;
         aen_q <= aen_d;
         bale_q <= bale_d;
         ready_q <= ready_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   // Channel check: a new error beats a clear in the same cycle
   always_comb begin
      chk_d = chk_q;
      if (err_clear)
         chk_d = 1'b0;
      if (!iochk_n)
         chk_d = 1'b1;
   end

   // Error flag and reset drive; reset drive drops at the first edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chk_q <= 1'b0;
         rstdrv_q <= RSTDRV_RST;
      end else begin
         chk_q <= chk_d;
         rstdrv_q <= 1'b0;
      end
   end

   // Standard commands follow whoever drives the memory commands
   assign bus_memr_n = memr_q.oe ? memr_q.o : memr_n_in;
   assign bus_memw_n = memw_q.oe ? memw_q.o : memw_n_in;
   assign low_meg = below_meg(la_oe_q ? la_q : la_in);

   std_mem_cmd u_std_mem_cmd (
      .clock(clock),
      .resetn(resetn),
      .memr_n(bus_memr_n),
      .memw_n(bus_memw_n),
      .low_meg(low_meg),
      .smemr_n(smemr_n),
      .smemw_n(smemw_n),
      .smem_oe(smem_oe)
   );

   // Outputs straight from flops
   assign req_ready = ready_q;
   assign done = done_q;
   assign rdata = rdata_q;
   assign chk_error = chk_q;
   assign la_out = la_q;
   assign la_oe = la_oe_q;
   assign sd_out = sd_q;
   assign sd_oe = sd_oe_q;
   assign sbhe_n_out = sbhe_q.o;
   assign sbhe_n_oe = sbhe_q.oe;
   assign memr_n_out = memr_q.o;
   assign memr_n_oe = memr_q.oe;
   assign memw_n_out = memw_q.o;
   assign memw_n_oe = memw_q.oe;
   assign aen = aen_q;
   assign bale = bale_q;
   assign rstdrv = rstdrv_q;
endmodule
`default_nettype wire

// *** core/isa_sig_pkg.sv ***
// Shared constants, types and carriers for the ISA bus signal control block
package isa_sig_pkg;
   // Bus widths
   localparam int ADDR_W = 24;
   localparam int LA_LSB = 17;
   localparam int LA_W = 7;
   localparam int SD_W = 16;
   // Lowest address bit above the 1 Mbyte boundary
   localparam int MEG_BIT = 20;
   // Clock and phase timing
   localparam int CLK_NS = 10;
   localparam int BALE_NS = 100;
   localparam int CMD_NS = 300;
   // Least times round up to whole cycles
   localparam int BALE_CYC = (BALE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CMD_CYC = (CMD_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   // Reset values of the pins
   localparam logic CMD_IDLE_N = 1'b1;
   localparam logic AEN_RST = 1'b0;
   localparam logic BALE_RST = 1'b0;
   localparam logic RSTDRV_RST = 1'b1;
   localparam logic [LA_W-1:0] LA_RST = 7'h00;
   localparam logic [SD_W-1:0] SD_RST = 16'h0000;

   // Kind of cycle the bridge runs on the ISA side
   typedef enum logic [2:0] {
      K_MEM_RD,
      K_MEM_WR,
      K_DMA_RD,
      K_DMA_WR,
      K_REFRESH
   } cyc_kind_t;

   // One cycle request from the bridge core
   typedef struct packed {
      cyc_kind_t kind;
      logic [ADDR_W-1:0] addr;
      logic bhe;
      logic [SD_W-1:0] wdata;
   } cyc_req_t;

   // One two-signal pin group, level as seen on the wire
   typedef struct packed {
      logic o;
      logic oe;
   } pin_drv_t;
endpackage

// *** core/std_mem_cmd.sv ***
// Delayed standard-memory commands gated to the first megabyte
`timescale 1ns/10ps
`default_nettype none
module std_mem_cmd
   import isa_sig_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Memory commands as they stand on the bus, active low
   input wire logic memr_n,
   input wire logic memw_n,
   // Access lies below 1 Mbyte
   input wire logic low_meg,
   // Delayed standard commands, driven after reset
   output logic smemr_n,
   output logic smemw_n,
   output logic smem_oe
);
   logic smemr_d, smemw_d, oe_d;   // Next values
   logic smemr_q, smemw_q, oe_q;   // Registered pins

   // One flop of delay follows the bus command
   always_comb begin
      smemr_d = memr_n | ~low_meg;
      smemw_d = memw_n | ~low_meg;
      oe_d = 1'b1;
   end

   // Pins float during reset, then stay driven
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         smemr_q <= CMD_IDLE_N;
         smemw_q <= CMD_IDLE_N;
         oe_q <= 1'b0;
      end else begin
         smemr_q <= smemr_d;
         smemw_q <= smemw_d;
         oe_q <= oe_d;
      end
   end

   assign smemr_n = smemr_q;
   assign smemw_n = smemw_q;
   assign smem_oe = oe_q;
endmodule
`default_nettype wire

// *** verification/isa_bus_signal_control_asserts.sv ***
// Port checker for the ISA signal control block
`timescale 1ns/10ps
`default_nettype none
module isa_bus_signal_control_asserts
   import isa_sig_pkg::*;
#(
   parameter int BALE_CYCLES = BALE_CYC,
   parameter int CMD_CYCLES = CMD_CYC
) (
   // Clock, reset, cycle port, status
   input wire logic clock, resetn, req_valid, req_ready, done, master_own, chk_error, iochk_n,
   input wire cyc_req_t req,
   // Pins
   input wire logic [LA_W-1:0] la_in, la_out,
   input wire logic [SD_W-1:0] sd_out,
   input wire logic la_oe, sd_oe, sbhe_n_out, sbhe_n_oe, memr_n_in, memr_n_out, memr_n_oe,
   input wire logic memw_n_in, memw_n_out, memw_n_oe, smemr_n, smemw_n, aen, bale
);
   localparam int LAT = BALE_CYCLES + CMD_CYCLES + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shadow of the cycle in flight; cnt_q is 1 on the edge after the take
   logic bsy_q, mr_q, mw_q, mid, dma, wr;
   int cnt_q;
   logic [3:0] hi_q;
   cyc_req_t rq_q;
   assign mid = bsy_q && cnt_q < LAT;
   assign dma = rq_q.kind inside {K_DMA_RD, K_DMA_WR};
   assign wr = rq_q.kind inside {K_MEM_WR, K_DMA_WR};
   // Commands and top address bits kept one edge back, as the standard commands lag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bsy_q <= 1'b0;
         cnt_q <= 0;
         rq_q <= '0;
         mr_q <= 1'b1;
         mw_q <= 1'b1;
         hi_q <= 4'h0;
      end else begin
         mr_q <= memr_n_in;
         mw_q <= memw_n_in;
         hi_q <= la_oe ? la_out[6:3] : la_in[6:3];
         cnt_q <= cnt_q + 1;
         if (!bsy_q && req_valid && req_ready && !master_own) begin
            bsy_q <= 1'b1;
            cnt_q <= 1;
            rq_q <= req;
         end else if (done) begin
            bsy_q <= 1'b0;
         end
      end
   end
   AST_DONE: assert property (done == (bsy_q && cnt_q == LAT))
      else $error("done off its fixed latency");
   AST_LA_DRV: assert property (bsy_q && cnt_q == 1 |->
      bale && la_oe && la_out == rq_q.addr[ADDR_W-1:LA_LSB]) else $error("address phase wrong");
   AST_OE_SAME: assert property (memr_n_oe == la_oe && memw_n_oe == la_oe &&
      sbhe_n_oe == la_oe) else $error("pin directions disagree");
   AST_LA_REL: assert property (master_own && $past(master_own) && !bsy_q |->
      !la_oe && bale && !req_ready) else $error("bus not handed to master");
   AST_AEN: assert property (mid |-> aen == (dma || rq_q.kind == K_REFRESH))
      else $error("aen wrong in cycle");
   AST_BALE_DMA: assert property (mid && dma |-> bale)
      else $error("bale dropped in dma");
   AST_SBHE: assert property (mid |-> sbhe_n_out == !(rq_q.bhe && rq_q.kind != K_REFRESH))
      else $error("byte high enable wrong");
   AST_CMD: assert property (bsy_q && cnt_q == BALE_CYCLES + 1 |->
      memr_n_out == wr && memw_n_out == !wr && bale == dma) else $error("command phase wrong");
   AST_WDATA: assert property (!memw_n_out && memw_n_oe |->
      sd_oe && sd_out == rq_q.wdata) else $error("write data not driven");
   AST_SMEMR: assert property (smemr_n == (mr_q || hi_q != 4'h0))
      else $error("standard read wrong");
   AST_SMEMW: assert property (smemw_n == (mw_q || hi_q != 4'h0))
      else $error("standard write wrong");
   AST_CHK: assert property (!iochk_n |=> chk_error)
      else $error("channel check not caught");
endmodule
bind isa_bus_signal_control isa_bus_signal_control_asserts #(
   .BALE_CYCLES(BALE_CYCLES), .CMD_CYCLES(CMD_CYCLES)) u_asserts (.clock, .resetn,
   .req_valid, .req_ready, .done, .master_own, .chk_error, .iochk_n, .req, .la_in, .la_out,
   .sd_out, .la_oe, .sd_oe, .sbhe_n_out, .sbhe_n_oe, .memr_n_in, .memr_n_out, .memr_n_oe,
   .memw_n_in, .memw_n_out, .memw_n_oe, .smemr_n, .smemw_n, .aen, .bale);
`default_nettype wire

// *** verification/isa_far_model.sv ***
// Far-side memory slave holding one word
`timescale 1ns/10ps
`default_nettype none
module isa_far_model
   import isa_sig_pkg::*;
(
   // Clock and bus lines as seen on the wire
   input wire logic clock,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic [SD_W-1:0] sd,
   // Data the slave puts on the bus
   output logic [SD_W-1:0] sd_drv
);
   // Stored word; last drive starts from an arbitrary pattern
   logic [SD_W-1:0] mem_q;
   logic [SD_W-1:0] drv_q = 16'h5a5a;
   // Released data toggles each cycle so stale values never pass as reads
   assign sd_drv = memr_n ? ~drv_q : mem_q;
   // Latch only under a write command, never during refresh
   always @(posedge clock) begin
      drv_q <= sd_drv;
      if (!memw_n) begin
         mem_q <= sd;
      end
   end
endmodule
`default_nettype wire

// *** verification/tb_isa_bus_signal_control.sv ***
// Self-checking bench for the ISA signal control block
`timescale 1ns/10ps
`default_nettype none
module tb_isa_bus_signal_control
   import isa_sig_pkg::*;
;
   localparam int LAT = 4;
   // Design ports
   logic clock, resetn, req_valid, req_ready, done, master_own, err_clear, chk_error;
   cyc_req_t req;
   logic [SD_W-1:0] rdata, sd_in, sd_out, sd_slv;
   logic [LA_W-1:0] la_in, la_out, m_la;
   logic la_oe, sd_oe, sbhe_n_in, sbhe_n_out, sbhe_n_oe, memr_n_in, memr_n_out, memr_n_oe;
   logic memw_n_in, memw_n_out, memw_n_oe, smemr_n, smemw_n, smem_oe, aen, bale, rstdrv;
   logic iochk_n, m_memr_n, m_memw_n;
   // Seen marks: aen high, smemr low, smemw low, sbhe low
   logic [3:0] seen;
   int errors, n_checks;
   // Wire levels; a pull-up keeps SBHE high when nobody drives; commands fall back to the master model
   assign la_in = la_oe ? la_out : m_la;
   assign sd_in = sd_oe ? sd_out : sd_slv;
   assign sbhe_n_in = sbhe_n_oe ? sbhe_n_out : 1'b1;
   assign memr_n_in = memr_n_oe ? memr_n_out : m_memr_n;
   assign memw_n_in = memw_n_oe ? memw_n_out : m_memw_n;
   isa_bus_signal_control #(.BALE_CYCLES(1), .CMD_CYCLES(2)) uut (.clock, .resetn,
      .req_valid, .req, .req_ready, .done, .rdata, .master_own, .err_clear, .chk_error,
      .la_in, .la_out, .la_oe, .sd_in, .sd_out, .sd_oe, .sbhe_n_in, .sbhe_n_out, .sbhe_n_oe,
      .memr_n_in, .memr_n_out, .memr_n_oe, .memw_n_in, .memw_n_out, .memw_n_oe, .smemr_n,
      .smemw_n, .smem_oe, .aen, .bale, .rstdrv, .iochk_n);
   isa_far_model mem (.clock, .memr_n(memr_n_in), .memw_n(memw_n_in), .sd(sd_in),
      .sd_drv(sd_slv));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Sampled mid-cycle, clear of the edge
   always @(negedge clock) begin
      seen <= seen | {aen === 1'b1, smemr_n === 1'b0, smemw_n === 1'b0, sbhe_n_out === 1'b0};
   end
   task automatic step(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One cycle through the request port; latency is counted from the take edge
   task automatic run(input cyc_kind_t k, input logic [23:0] a, input logic [15:0] w);
      int n;
      req = '{kind: k, addr: a, bhe: 1'b1, wdata: w};
      req_valid = 1'b1;
      for (n = 0; req_ready !== 1'b1 && n < 50; n++) step();
      step();
      req_valid = 1'b0;
      // Cleared only after the take: the standard commands of the last cycle lag one edge
      seen = 4'h0;
      for (n = 1; done !== 1'b1 && n < 50; n++) step();
      chk(n, LAT);
   endtask
   task automatic t_mem(input logic [23:0] a, input logic [15:0] w, input logic [3:0] e);
      run(K_MEM_WR, a, w);
      chk(seen, e);
      chk(mem.mem_q, w);
      run(K_MEM_RD, a, 16'h0000);
      chk(seen, {e[3], e[1], e[2], e[0]});
      chk(rdata, w);
   endtask
   task automatic t_kinds();
      cyc_kind_t k[3] = '{K_DMA_WR, K_DMA_RD, K_REFRESH};
      logic [3:0] e[3] = '{4'hb, 4'hd, 4'hc};
      for (int i = 0; i < 3; i++) begin
         run(k[i], 24'h00_0000, 16'h1234);
         chk(seen, e[i]);
      end
      chk(rdata, 16'h1234);
   endtask
   // Request held while the external master owns the bus must be refused
   task automatic t_master();
      master_own = 1'b1;
      req = '{kind: K_MEM_RD, addr: 24'h00_0000, bhe: 1'b0, wdata: 16'h0000};
      req_valid = 1'b1;
      step(2);
      chk({la_oe, memr_n_oe, bale, req_ready}, 4'h2);
      m_la = 7'h05;
      step();
      m_memr_n = 1'b0;
      seen = 4'h0;
      step(3);
      chk({seen[2], done}, 2'h2);
      m_memr_n = 1'b1;
      req_valid = 1'b0;
      step(2);
      master_own = 1'b0;
      m_la = 7'h7f;
      step(3);
      chk(la_oe, 1'b1);
   endtask
   task automatic t_chk();
      iochk_n = 1'b0;
      step();
      iochk_n = 1'b1;
      step(3);
      chk(chk_error, 1'b1);
      err_clear = 1'b1;
      step();
      err_clear = 1'b0;
      step();
      chk(chk_error, 1'b0);
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      results();
   end
   initial begin
      errors = 0;
      n_checks = 0;
      {resetn, req_valid, master_own, err_clear} = 4'h0;
      {iochk_n, m_memr_n, m_memw_n} = 3'h7;
      req = '0;
      m_la = 7'h7f;
      seen = 4'h0;
      step(4);
      chk({rstdrv, la_oe, aen, bale}, 4'h8);
      resetn = 1'b1;
      step(2);
      chk({rstdrv, la_oe, smem_oe, smemr_n}, 4'h7);
      t_mem(24'h0e_1234, 16'ha5c3, 4'h3);
      t_mem(24'h10_0000, 16'h5a3c, 4'h1);
      t_kinds();
      t_master();
      t_chk();
      results();
   end
endmodule
`default_nettype wire
